/* File: logic/ddrw_pkg.sv */
package ddrw_pkg;

	// Burst-length field encodings of mode register zero.
	localparam logic [1:0] BL_FULL_FIXED = 2'h0;
	localparam logic [1:0] BL_ON_THE_FLY = 2'h1;
	localparam logic [1:0] BL_CHOP_FIXED = 2'h2;

	// Beats per burst.
	localparam logic [3:0] FULL_EIGHT_BEAT_BURST   = 4'h8;
	localparam logic [3:0] CHOPPED_FOUR_BEAT_BURST = 4'h4;

	// Command codes on the link.
	localparam logic [1:0] OP_MODE  = 2'h0;
	localparam logic [1:0] OP_WRITE = 2'h1;
	localparam logic [1:0] OP_READ  = 2'h2;
	localparam logic [1:0] OP_PRE   = 2'h3;

	// Timing counts in command clock cycles.
	localparam logic [5:0] PARITY_LATENCY_CYC         = 6'h04;
	localparam logic [5:0] WRITE_COLUMN_LATENCY_RST   = 6'h09;
	localparam logic [5:0] ADDITIVE_LATENCY_RST       = 6'h00;
	localparam logic [5:0] WRITE_RECOVERY_CYC         = 6'h0c;
	localparam logic [5:0] INVERSION_WRITE_RECOVERY_CYC = 6'h0e;
	localparam logic [5:0] WRITE_TO_READ_SAME_GROUP_CYC = 6'h06;
	localparam logic [5:0] WRITE_TO_READ_OTHER_GROUP_CYC = 6'h02;
	localparam logic [5:0] INVERSION_WTR_SAME_GROUP_CYC  = 6'h08;
	localparam logic [5:0] INVERSION_WTR_OTHER_GROUP_CYC = 6'h04;

	typedef enum logic [2:0] {
		ST_IDLE = 3'b001,
		ST_LAT  = 3'b010,
		ST_DATA = 3'b100
	} ddrw_state_t;

	function automatic logic [3:0] burst_beats(input logic [1:0] bl, input logic bsel);
		logic [3:0] n;
		n = FULL_EIGHT_BEAT_BURST;
		if (bl == BL_CHOP_FIXED)
			n = CHOPPED_FOUR_BEAT_BURST;
		else if (bl == BL_ON_THE_FLY && !bsel)
			n = CHOPPED_FOUR_BEAT_BURST;
		return n;
	endfunction

	function automatic logic [5:0] write_latency(input logic [5:0] al, input logic [5:0] wcl,
			input logic pl_en);
		return 6'(al + wcl + (pl_en ? PARITY_LATENCY_CYC : 6'h00));
	endfunction

endpackage

/* File: logic/ddrw_if.sv */
`timescale 1ns/1ps
interface ddrw_if;
	logic        cmd_valid;
	logic [1:0]  cmd_op;
	logic [1:0]  cmd_bank;
	logic        cmd_group;
	logic        burst_select_address_bit;
	logic        cmd_ap;
	logic [1:0]  mode_bl;
	logic [5:0]  mode_wcl;
	logic [5:0]  mode_al;
	logic        mode_pl_en;
	logic        mode_dbi_en;
	logic [5:0]  mode_wr;
	logic [15:0] dq;
	logic        dq_valid;
	logic        dq_dbi_n;
	logic        dev_ready;

	modport ctrl (
		output cmd_valid, cmd_op, cmd_bank, cmd_group, burst_select_address_bit, cmd_ap,
		output mode_bl, mode_wcl, mode_al, mode_pl_en, mode_dbi_en, mode_wr,
		output dq, dq_valid, dq_dbi_n,
		input  dev_ready
	);
	modport dev (
		input  cmd_valid, cmd_op, cmd_bank, cmd_group, burst_select_address_bit, cmd_ap,
		input  mode_bl, mode_wcl, mode_al, mode_pl_en, mode_dbi_en, mode_wr,
		input  dq, dq_valid, dq_dbi_n,
		output dev_ready
	);
endinterface

/* File: logic/ddrw_fifo.sv */
`timescale 1ns/1ps
module ddrw_fifo #(
	parameter int WIDTH = 17,
	parameter int DEPTH = 16
) (
	input  wire logic             sys_clk_i,
	input  wire logic             rst_i,
	input  wire logic             in_valid_i,
	output logic                  in_ready_o,
	input  wire logic [WIDTH-1:0] in_data_i,
	output logic                  out_valid_o,
	input  wire logic             out_ready_i,
	output logic [WIDTH-1:0]      out_data_o,
	output logic [$clog2(DEPTH):0] level_o
);
	localparam int AW = $clog2(DEPTH);

	if (DEPTH < 2 || (1 << AW) != DEPTH) begin : g_bad_depth
		$error("ddrw_fifo: DEPTH must be a power of two of at least 2");
	end

	logic [WIDTH-1:0] mem [DEPTH];
	logic [AW:0]      wr_q;
	logic [AW:0]      rd_q;

	wire push = in_valid_i && in_ready_o;
	wire pop  = out_valid_o && out_ready_i;

	assign level_o     = wr_q - rd_q;
	assign in_ready_o  = !((wr_q[AW] != rd_q[AW]) && (wr_q[AW-1:0] == rd_q[AW-1:0]));
	assign out_valid_o = (wr_q != rd_q);
	assign out_data_o  = mem[rd_q[AW-1:0]];

	always_ff @(posedge sys_clk_i) begin
		if (push)
			mem[wr_q[AW-1:0]] <= in_data_i;
	end

	always_ff @(posedge sys_clk_i or posedge rst_i) begin
		if (rst_i) begin
			wr_q <= '0;
			rd_q <= '0;
		end else begin
			if (push)
				wr_q <= wr_q + 1'b1;
			if (pop)
				rd_q <= rd_q + 1'b1;
		end
	end
endmodule

/* File: logic/ddrw_dev.sv */
`timescale 1ns/1ps
module ddrw_dev #(
	parameter int FIFO_DEPTH = 16
) (
	input  wire logic  sys_clk_i,
	input  wire logic  rst_i,
	ddrw_if.dev        link,
	output logic [16:0] wdat_o,
	output logic        wdat_valid_o,
	input  wire logic   wdat_ready_i,
	output logic        pre_o,
	output logic [1:0]  pre_bank_o
);
	ddrw_pkg::ddrw_state_t st_q;
	logic [1:0] bl_q;
	logic [5:0] wcl_q;
	logic [5:0] al_q;
	logic       pl_en_q;
	logic       dbi_en_q;
	logic [5:0] wr_q;
	logic [5:0] lat_q;
	logic [3:0] beats_q;
	logic [3:0] beat_q;
	logic       ap_q;
	logic [1:0] bank_q;
	logic [5:0] ap_cnt_q;
	logic       ready_q;
	logic       pre_q;
	logic [1:0] pre_bank_q;

	logic [4:0] level;
	logic       fifo_in_ready;

	wire cmd_mode  = link.cmd_valid && link.cmd_op == ddrw_pkg::OP_MODE;
	wire cmd_write = link.cmd_valid && link.cmd_op == ddrw_pkg::OP_WRITE && ready_q;
	wire cmd_pre   = link.cmd_valid && link.cmd_op == ddrw_pkg::OP_PRE;
	wire [5:0] wl  = ddrw_pkg::write_latency(al_q, wcl_q, pl_en_q);
	wire [3:0] nbeats = ddrw_pkg::burst_beats(bl_q, link.burst_select_address_bit);
	wire sample    = st_q == ddrw_pkg::ST_DATA;
	wire last_beat = sample && (beat_q == beats_q - 4'h1);
	// Inverted beats are restored before they are stored.
	wire [15:0] din = (dbi_en_q && !link.dq_dbi_n) ? ~link.dq : link.dq;
	wire ap_fire    = ap_q && st_q == ddrw_pkg::ST_IDLE && ap_cnt_q == 6'h01;
	// Room for a whole full burst is demanded so that a burst is never cut short.
	wire room       = fifo_in_ready && (level <= 5'(FIFO_DEPTH - 8));

	// The level is five bits wide and room is judged for one full burst.
	if (FIFO_DEPTH < 8 || FIFO_DEPTH > 16) begin : g_bad_depth
		$error("ddrw_dev: FIFO_DEPTH must lie between 8 and 16");
	end

	assign link.dev_ready = ready_q;
	assign pre_o          = pre_q;
	assign pre_bank_o     = pre_bank_q;

	ddrw_fifo #(.WIDTH(17), .DEPTH(FIFO_DEPTH)) u_fifo (
		.sys_clk_i   (sys_clk_i),
		.rst_i       (rst_i),
		.in_valid_i  (sample),
		.in_ready_o  (fifo_in_ready),
		.in_data_i   ({last_beat, din}),
		.out_valid_o (wdat_valid_o),
		.out_ready_i (wdat_ready_i),
		.out_data_o  (wdat_o),
		.level_o     (level)
	);

	always_ff @(posedge sys_clk_i or posedge rst_i) begin
		if (rst_i) begin
			bl_q     <= ddrw_pkg::BL_FULL_FIXED;
			wcl_q    <= ddrw_pkg::WRITE_COLUMN_LATENCY_RST;
			al_q     <= ddrw_pkg::ADDITIVE_LATENCY_RST;
			pl_en_q  <= 1'b0;
			dbi_en_q <= 1'b0;
			wr_q     <= ddrw_pkg::WRITE_RECOVERY_CYC;
		end else if (cmd_mode && st_q == ddrw_pkg::ST_IDLE) begin
			bl_q     <= link.mode_bl;
			wcl_q    <= link.mode_wcl;
			al_q     <= link.mode_al;
			pl_en_q  <= link.mode_pl_en;
			dbi_en_q <= link.mode_dbi_en;
			wr_q     <= link.mode_wr;
		end
	end

	always_ff @(posedge sys_clk_i or posedge rst_i) begin
		if (rst_i) begin
			st_q    <= ddrw_pkg::ST_IDLE;
			lat_q   <= '0;
			beats_q <= '0;
			beat_q  <= '0;
			bank_q  <= '0;
		end else begin
			unique case (st_q)
				ddrw_pkg::ST_IDLE: begin
					if (cmd_write) begin
						st_q    <= ddrw_pkg::ST_LAT;
						lat_q   <= wl - 6'h01;
						beats_q <= nbeats;
						beat_q  <= '0;
						bank_q  <= link.cmd_bank;
					end
				end
				ddrw_pkg::ST_LAT: begin
					lat_q <= lat_q - 6'h01;
					if (lat_q == 6'h01)
						st_q <= ddrw_pkg::ST_DATA;
				end
				ddrw_pkg::ST_DATA: begin
					beat_q <= beat_q + 4'h1;
					if (last_beat)
						st_q <= ddrw_pkg::ST_IDLE;
				end
			endcase
		end
	end

	always_ff @(posedge sys_clk_i or posedge rst_i) begin
		if (rst_i) begin
			ap_q     <= 1'b0;
			ap_cnt_q <= '0;
		end else if (cmd_write) begin
			ap_q <= link.cmd_ap;
		end else if (last_beat) begin
			ap_cnt_q <= wr_q;
		end else if (ap_fire) begin
			ap_q     <= 1'b0;
			ap_cnt_q <= '0;
		end else if (ap_cnt_q != 6'h00) begin
			ap_cnt_q <= ap_cnt_q - 6'h01;
		end
	end

	always_ff @(posedge sys_clk_i or posedge rst_i) begin
		if (rst_i) begin
			ready_q    <= 1'b0;
			pre_q      <= 1'b0;
			pre_bank_q <= '0;
		end else begin
			ready_q    <= st_q == ddrw_pkg::ST_IDLE && !cmd_write && !ap_q && room;
			pre_q      <= ap_fire || cmd_pre;
			pre_bank_q <= ap_fire ? bank_q : link.cmd_bank;
		end
	end
endmodule

/* File: logic/ddrw_ctrl.sv */
`timescale 1ns/1ps
module ddrw_ctrl (
	input  wire logic         sys_clk_i,
	input  wire logic         rst_i,
	ddrw_if.ctrl              link,
	input  wire logic [1:0]   cfg_bl_i,
	input  wire logic [5:0]   cfg_wcl_i,
	input  wire logic [5:0]   cfg_al_i,
	input  wire logic         cfg_pl_en_i,
	input  wire logic         cfg_dbi_en_i,
	input  wire logic [5:0]   cfg_wr_i,
	input  wire logic         cfg_load_i,
	input  wire logic         req_valid_i,
	input  wire logic [1:0]   req_op_i,
	input  wire logic [1:0]   req_bank_i,
	input  wire logic         req_group_i,
	input  wire logic         req_bsel_i,
	input  wire logic         req_ap_i,
	input  wire logic [127:0] req_wdata_i,
	output logic              req_ready_o,
	output logic              busy_o
);
	ddrw_pkg::ddrw_state_t st_q;

	logic         cmd_valid_q;
	logic [1:0]   cmd_op_q;
	logic [1:0]   cmd_bank_q;
	logic         cmd_group_q;
	logic         cmd_bsel_q;
	logic         cmd_ap_q;
	logic [1:0]   bl_q;
	logic [5:0]   wcl_q;
	logic [5:0]   al_q;
	logic         pl_en_q;
	logic         dbi_en_q;
	logic [5:0]   wr_q;
	logic [15:0]  dq_q;
	logic         dq_valid_q;
	logic         dq_dbi_n_q;
	logic [5:0]   lat_q;
	logic [3:0]   beats_q;
	logic [3:0]   beat_q;
	logic [127:0] data_q;
	logic [1:0]   wbank_q;
	logic         wgroup_q;
	logic [5:0]   rec_q [4];
	logic [5:0]   wtr_same_q;
	logic [5:0]   wtr_other_q;
	logic         ready_q;
	logic         busy_q;

	wire idle      = st_q == ddrw_pkg::ST_IDLE && !cmd_valid_q;
	wire [5:0] wl  = ddrw_pkg::write_latency(al_q, wcl_q, pl_en_q);
	wire [3:0] nbeats = ddrw_pkg::burst_beats(bl_q, req_bsel_i);
	wire in_data   = st_q == ddrw_pkg::ST_DATA;
	wire last_sent = in_data && (beat_q == beats_q);
	wire [15:0] word = data_q[15:0];

	// With inversion the long recovery figures replace the normal ones.
	wire [5:0] rec_load  = dbi_en_q ? ddrw_pkg::INVERSION_WRITE_RECOVERY_CYC
	                                : wr_q;
	wire [5:0] same_load = dbi_en_q ? ddrw_pkg::INVERSION_WTR_SAME_GROUP_CYC
	                                : ddrw_pkg::WRITE_TO_READ_SAME_GROUP_CYC;
	wire [5:0] other_load = dbi_en_q ? ddrw_pkg::INVERSION_WTR_OTHER_GROUP_CYC
	                                 : ddrw_pkg::WRITE_TO_READ_OTHER_GROUP_CYC;

	wire pre_ok  = rec_q[req_bank_i] == 6'h00;
	wire read_ok = wtr_other_q == 6'h00 &&
	               (req_group_i != wgroup_q || wtr_same_q == 6'h00);

	wire take_write = req_op_i == ddrw_pkg::OP_WRITE && link.dev_ready;
	wire take_read  = req_op_i == ddrw_pkg::OP_READ && read_ok;
	wire take_pre   = req_op_i == ddrw_pkg::OP_PRE && pre_ok;
	wire take_mode  = req_op_i == ddrw_pkg::OP_MODE;
	wire accept     = idle && !cfg_load_i && req_valid_i &&
	                  (take_write || take_read || take_pre || take_mode);
	wire accept_wr  = accept && req_op_i == ddrw_pkg::OP_WRITE;
	wire load_mode  = idle && cfg_load_i;

	function automatic logic many_ones(input logic [15:0] w);
		logic [4:0] n;
		n = '0;
		for (int i = 0; i < 16; i++)
			n = n + 5'(w[i]);
		return n > 5'h08;
	endfunction

	assign link.cmd_valid                = cmd_valid_q;
	assign link.cmd_op                   = cmd_op_q;
	assign link.cmd_bank                 = cmd_bank_q;
	assign link.cmd_group                = cmd_group_q;
	assign link.burst_select_address_bit = cmd_bsel_q;
	assign link.cmd_ap                   = cmd_ap_q;
	assign link.mode_bl                  = bl_q;
	assign link.mode_wcl                 = wcl_q;
	assign link.mode_al                  = al_q;
	assign link.mode_pl_en               = pl_en_q;
	assign link.mode_dbi_en              = dbi_en_q;
	assign link.mode_wr                  = wr_q;
	assign link.dq                       = dq_q;
	assign link.dq_valid                 = dq_valid_q;
	assign link.dq_dbi_n                 = dq_dbi_n_q;
	assign req_ready_o                   = ready_q;
	assign busy_o                        = busy_q;

	always_ff @(posedge sys_clk_i or posedge rst_i) begin
		if (rst_i) begin
			bl_q     <= ddrw_pkg::BL_FULL_FIXED;
			wcl_q    <= ddrw_pkg::WRITE_COLUMN_LATENCY_RST;
			al_q     <= ddrw_pkg::ADDITIVE_LATENCY_RST;
			pl_en_q  <= 1'b0;
			dbi_en_q <= 1'b0;
			wr_q     <= ddrw_pkg::WRITE_RECOVERY_CYC;
		end else if (load_mode) begin
			bl_q     <= cfg_bl_i;
			wcl_q    <= cfg_wcl_i;
			al_q     <= cfg_al_i;
			pl_en_q  <= cfg_pl_en_i;
			dbi_en_q <= cfg_dbi_en_i;
			wr_q     <= cfg_wr_i;
		end
	end

	always_ff @(posedge sys_clk_i or posedge rst_i) begin
		if (rst_i) begin
			cmd_valid_q <= 1'b0;
			cmd_op_q    <= ddrw_pkg::OP_MODE;
			cmd_bank_q  <= '0;
			cmd_group_q <= 1'b0;
			cmd_bsel_q  <= 1'b0;
			cmd_ap_q    <= 1'b0;
		end else begin
			cmd_valid_q <= load_mode || accept;
			cmd_op_q    <= load_mode ? ddrw_pkg::OP_MODE : req_op_i;
			cmd_bank_q  <= req_bank_i;
			cmd_group_q <= req_group_i;
			cmd_bsel_q  <= req_bsel_i;
			cmd_ap_q    <= req_ap_i && accept_wr;
		end
	end

	// The data path mirrors the device's latency count so both ends agree on beat zero.
	always_ff @(posedge sys_clk_i or posedge rst_i) begin
		if (rst_i) begin
			st_q       <= ddrw_pkg::ST_IDLE;
			lat_q      <= '0;
			beats_q    <= '0;
			beat_q     <= '0;
			data_q     <= '0;
			wbank_q    <= '0;
			dq_q       <= '0;
			dq_valid_q <= 1'b0;
			dq_dbi_n_q <= 1'b1;
		end else begin
			unique case (st_q)
				ddrw_pkg::ST_IDLE: begin
					dq_valid_q <= 1'b0;
					if (accept_wr) begin
						st_q    <= ddrw_pkg::ST_LAT;
						lat_q   <= wl - 6'h01;
						beats_q <= nbeats;
						beat_q  <= '0;
						data_q  <= req_wdata_i;
						wbank_q <= req_bank_i;
					end
				end
				ddrw_pkg::ST_LAT: begin
					lat_q <= lat_q - 6'h01;
					// Same count as the device, so beat zero stands when the device samples.
					if (lat_q == 6'h01)
						st_q <= ddrw_pkg::ST_DATA;
				end
				ddrw_pkg::ST_DATA: begin
					if (last_sent) begin
						st_q       <= ddrw_pkg::ST_IDLE;
						dq_valid_q <= 1'b0;
					end else begin
						dq_valid_q <= 1'b1;
						dq_dbi_n_q <= !(dbi_en_q && many_ones(word));
						dq_q       <= (dbi_en_q && many_ones(word)) ? ~word : word;
						data_q     <= {16'h0000, data_q[127:16]};
						beat_q     <= beat_q + 4'h1;
					end
				end
			endcase
		end
	end

	// Counters load on the edge that closes the last beat, so zero marks the earliest
	// legal command.
	always_ff @(posedge sys_clk_i or posedge rst_i) begin
		if (rst_i) begin
			for (int b = 0; b < 4; b++)
				rec_q[b] <= '0;
			wtr_same_q  <= '0;
			wtr_other_q <= '0;
			wgroup_q    <= 1'b0;
		end else begin
			for (int b = 0; b < 4; b++) begin
				if (last_sent && 2'(b) == wbank_q)
					rec_q[b] <= rec_load - 6'h01;
				else if (rec_q[b] != 6'h00)
					rec_q[b] <= rec_q[b] - 6'h01;
			end
			if (last_sent) begin
				wtr_same_q  <= same_load - 6'h01;
				wtr_other_q <= other_load - 6'h01;
			end else begin
				if (wtr_same_q != 6'h00)
					wtr_same_q <= wtr_same_q - 6'h01;
				if (wtr_other_q != 6'h00)
					wtr_other_q <= wtr_other_q - 6'h01;
			end
			// The group is taken at acceptance, since the command lines follow later requests.
			if (accept_wr)
				wgroup_q <= req_group_i;
		end
	end

	always_ff @(posedge sys_clk_i or posedge rst_i) begin
		if (rst_i) begin
			ready_q <= 1'b0;
			busy_q  <= 1'b0;
		end else begin
			ready_q <= accept;
			busy_q  <= st_q != ddrw_pkg::ST_IDLE || accept_wr;
		end
	end
endmodule

/* File: tb/ddrw_link_chk.sv */
`timescale 1ns/1ps
module ddrw_link_chk (
	input wire logic       sys_clk_i,
	input wire logic       rst_i,
	input wire logic       cmd_valid,
	input wire logic [1:0] cmd_op,
	input wire logic [1:0] cmd_bank,
	input wire logic       cmd_group,
	input wire logic       burst_select_address_bit,
	input wire logic [1:0] mode_bl,
	input wire logic [5:0] mode_wcl,
	input wire logic [5:0] mode_al,
	input wire logic       mode_pl_en,
	input wire logic       mode_dbi_en,
	input wire logic [5:0] mode_wr,
	input wire logic       dq_valid
);
	logic [5:0] since_q;
	logic [1:0] wbank_q;
	logic       wgrp_q;
	wire        wr_cmd = cmd_valid && cmd_op == ddrw_pkg::OP_WRITE;
	wire        wl9 = mode_al == 6'h00 && mode_wcl == 6'h09;
	wire        base = wl9 && !mode_pl_en;
	wire        rd = cmd_valid && cmd_op == ddrw_pkg::OP_READ;
	wire        pre_same = cmd_valid && cmd_op == ddrw_pkg::OP_PRE && cmd_bank == wbank_q;

	// The count saturates, so a command long after any write is never flagged as too early.
	always_ff @(posedge sys_clk_i or posedge rst_i) begin
		if (rst_i) begin
			since_q <= 6'h3f;
			wbank_q <= 2'h0;
			wgrp_q <= 1'b0;
		end else begin
			if (dq_valid)
				since_q <= 6'h00;
			else if (since_q != 6'h3f)
				since_q <= since_q + 6'h01;
			if (wr_cmd) begin
				wbank_q <= cmd_bank;
				wgrp_q <= cmd_group;
			end
		end
	end

	default clocking cb @(posedge sys_clk_i); endclocking
	default disable iff (rst_i);

	chop_fixed_a: assert property (
		wr_cmd && base && mode_bl == ddrw_pkg::BL_CHOP_FIXED |-> ##9 dq_valid [*4] ##1 !dq_valid)
		else $error("fixed chopped burst wrong");
	otf_chop_a: assert property (
		wr_cmd && base && mode_bl == ddrw_pkg::BL_ON_THE_FLY && !burst_select_address_bit
		|-> ##9 dq_valid [*4] ##1 !dq_valid)
		else $error("on the fly chopped burst wrong");
	full_burst_a: assert property (
		wr_cmd && base && (mode_bl == ddrw_pkg::BL_FULL_FIXED
		|| (mode_bl == ddrw_pkg::BL_ON_THE_FLY && burst_select_address_bit))
		|-> ##9 dq_valid [*8] ##1 !dq_valid)
		else $error("full burst wrong");
	parity_lat_a: assert property (
		wr_cmd && wl9 && mode_pl_en |-> ##1 !dq_valid [*8] ##4 !dq_valid ##1 dq_valid)
		else $error("parity write latency wrong");
	wtr_same_a: assert property (
		rd && cmd_group == wgrp_q && !mode_dbi_en
		|-> since_q >= ddrw_pkg::WRITE_TO_READ_SAME_GROUP_CYC)
		else $error("same group read too early");
	wtr_other_a: assert property (
		rd && cmd_group != wgrp_q && !mode_dbi_en
		|-> since_q >= ddrw_pkg::WRITE_TO_READ_OTHER_GROUP_CYC)
		else $error("other group read too early");
	wtr_inv_a: assert property (
		rd && cmd_group == wgrp_q && mode_dbi_en
		|-> since_q >= ddrw_pkg::INVERSION_WTR_SAME_GROUP_CYC)
		else $error("inverted same group read too early");
	recov_a: assert property (
		pre_same && !mode_dbi_en |-> since_q >= mode_wr)
		else $error("precharge before recovery");
	recov_inv_a: assert property (
		pre_same && mode_dbi_en |-> since_q >= ddrw_pkg::INVERSION_WRITE_RECOVERY_CYC)
		else $error("precharge before inverted recovery");

	cover property (wr_cmd && mode_bl == ddrw_pkg::BL_CHOP_FIXED);
	cover property (pre_same && mode_dbi_en);
	cover property (rd && cmd_group == wgrp_q);
endmodule

/* File: tb/dram_write_burst_timing_tb.sv */
`timescale 1ns/1ps
module dram_write_burst_timing_tb;
	logic		sys_clk_i = 1'b0;
	logic		rst_i = 1'b1;
	logic [1:0]	cfg_bl_i = 2'h0;
	logic [5:0]	cfg_wcl_i = 6'h09;
	logic [5:0]	cfg_al_i = 6'h00;
	logic		cfg_pl_en_i = 1'b0;
	logic		cfg_dbi_en_i = 1'b0;
	logic [5:0]	cfg_wr_i = 6'h0c;
	logic		cfg_load_i = 1'b0;
	logic		req_valid_i = 1'b0;
	logic [1:0]	req_op_i = 2'h0;
	logic [1:0]	req_bank_i = 2'h0;
	logic		req_group_i = 1'b0;
	logic		req_bsel_i = 1'b0;
	logic		req_ap_i = 1'b0;
	logic [127:0]	req_wdata_i = 128'h0;
	logic		wdat_ready_i = 1'b1;
	logic		req_ready_o, busy_o, wdat_valid_o, pre_o;
	logic		dq_prev = 1'b0;
	logic [16:0]	wdat_o;
	logic [1:0]	pre_bank_o, pre_bank;
	logic [16:0]	got_q[$], exp_q[$];
	int		cyc, rdy_cyc, last_cyc, first_cyc, pre_cyc, pre_cnt, old, error_cnt, checks_done;
	bit		got;
	logic [1:0]	bl_t[8] = '{2'h2, 2'h2, 2'h1, 2'h1, 2'h0, 2'h0, 2'h0, 2'h0};
	logic [5:0]	wcl_t[8] = '{6'h09, 6'h09, 6'h09, 6'h09, 6'h09, 6'h09, 6'h09, 6'h0a};
	logic [5:0]	al_t[8] = '{6'h00, 6'h00, 6'h00, 6'h00, 6'h00, 6'h00, 6'h00, 6'h02};
	logic		pl_t[8] = '{1'b0, 1'b0, 1'b0, 1'b0, 1'b0, 1'b0, 1'b1, 1'b0};
	int		n_t[8] = '{4, 4, 4, 8, 8, 8, 8, 8};
	int		lat_t[8] = '{9, 9, 9, 9, 9, 9, 13, 12};
	logic		dbi_t[5] = '{1'b0, 1'b1, 1'b0, 1'b0, 1'b1};
	logic		wg_t[5] = '{1'b0, 1'b0, 1'b1, 1'b0, 1'b1};
	logic [1:0]	op_t[5] = '{2'h3, 2'h3, 2'h2, 2'h2, 2'h2};
	int		lo_t[5] = '{13, 15, 7, 3, 9};

	always #20 sys_clk_i = ~sys_clk_i;

	ddrw_if link_if();
	ddrw_ctrl ddrw_ctrl_i (.sys_clk_i(sys_clk_i), .rst_i(rst_i), .link(link_if),
		.cfg_bl_i(cfg_bl_i), .cfg_wcl_i(cfg_wcl_i), .cfg_al_i(cfg_al_i),
		.cfg_pl_en_i(cfg_pl_en_i), .cfg_dbi_en_i(cfg_dbi_en_i), .cfg_wr_i(cfg_wr_i),
		.cfg_load_i(cfg_load_i), .req_valid_i(req_valid_i), .req_op_i(req_op_i),
		.req_bank_i(req_bank_i), .req_group_i(req_group_i), .req_bsel_i(req_bsel_i),
		.req_ap_i(req_ap_i), .req_wdata_i(req_wdata_i), .req_ready_o(req_ready_o),
		.busy_o(busy_o));
	ddrw_dev #(.FIFO_DEPTH(16)) ddrw_dev_i (.sys_clk_i(sys_clk_i), .rst_i(rst_i),
		.link(link_if), .wdat_o(wdat_o), .wdat_valid_o(wdat_valid_o),
		.wdat_ready_i(wdat_ready_i), .pre_o(pre_o), .pre_bank_o(pre_bank_o));
	ddrw_link_chk ddrw_link_chk_i (.sys_clk_i(sys_clk_i), .rst_i(rst_i),
		.cmd_valid(link_if.cmd_valid), .cmd_op(link_if.cmd_op), .cmd_bank(link_if.cmd_bank),
		.cmd_group(link_if.cmd_group), .mode_bl(link_if.mode_bl),
		.burst_select_address_bit(link_if.burst_select_address_bit),
		.mode_wcl(link_if.mode_wcl), .mode_al(link_if.mode_al), .mode_wr(link_if.mode_wr),
		.mode_pl_en(link_if.mode_pl_en), .mode_dbi_en(link_if.mode_dbi_en),
		.dq_valid(link_if.dq_valid));

	always @(posedge sys_clk_i) begin
		cyc <= cyc + 1;
		dq_prev <= link_if.dq_valid;
		if (link_if.dq_valid === 1'b1) begin
			last_cyc <= cyc;
			if (dq_prev !== 1'b1)
				first_cyc <= cyc;
		end
		if (wdat_valid_o === 1'b1 && wdat_ready_i)
			got_q.push_back(wdat_o);
		if (pre_o === 1'b1) begin
			pre_cnt <= pre_cnt + 1;
			pre_cyc <= cyc;
			pre_bank <= pre_bank_o;
		end
	end

	task automatic cmp(input string what, input logic [16:0] exp, input logic [16:0] seen);
		checks_done++;
		if (seen !== exp) begin
			error_cnt++;
			$display("wrong value %s: expected %h, seen %h", what, exp, seen);
		end
	endtask

	task automatic cmp_rng(input string what, input int lo, input int hi, input int seen);
		checks_done++;
		if (seen < lo || seen > hi) begin
			error_cnt++;
			$display("wrong value %s: expected %0d..%0d, seen %0d", what, lo, hi, seen);
		end
	endtask

	task automatic wait_rdy(input int lim);
		got = 1'b0;
		for (int i = 0; i < lim && !got; i++) begin
			@(posedge sys_clk_i);
			if (req_ready_o === 1'b1) begin
				got = 1'b1;
				rdy_cyc = cyc;
				req_valid_i <= 1'b0;
			end
		end
	endtask

	task automatic send(input logic [1:0] op, bank, input logic grp, bsel, ap, input int lim);
		@(posedge sys_clk_i);
		req_op_i <= op;
		req_bank_i <= bank;
		req_group_i <= grp;
		req_bsel_i <= bsel;
		req_ap_i <= ap;
		req_valid_i <= 1'b1;
		wait_rdy(lim);
	endtask

	// The mode command is sent after every load so the device always holds the new fields.
	task automatic cfg(input logic [1:0] bl, input logic [5:0] wcl, al, input logic pl, data_bus_inversion,
		input logic [5:0] wr);
		@(posedge sys_clk_i);
		cfg_bl_i <= bl;
		cfg_wcl_i <= wcl;
		cfg_al_i <= al;
		cfg_pl_en_i <= pl;
		cfg_dbi_en_i <= data_bus_inversion;
		cfg_wr_i <= wr;
		cfg_load_i <= 1'b1;
		@(posedge sys_clk_i);
		cfg_load_i <= 1'b0;
		send(ddrw_pkg::OP_MODE, 2'h0, 1'b0, 1'b0, 1'b0, 50);
		cmp("mode field", {15'h0, bl}, {15'h0, link_if.mode_bl});
	endtask

	task automatic write(input logic [1:0] bank, input logic grp, bsel, ap, input int n,
		input logic [7:0] seed, input int lim);
		for (int k = 0; k < 8; k++) begin
			req_wdata_i[16*k +: 16] <= {seed, 8'(k)};
			if (k < n)
				exp_q.push_back({k == n - 1, seed, 8'(k)});
		end
		send(ddrw_pkg::OP_WRITE, bank, grp, bsel, ap, lim);
	endtask

	task automatic check_data();
		for (int i = 0; i < 300 && got_q.size() < exp_q.size(); i++)
			@(posedge sys_clk_i);
		repeat (4) @(posedge sys_clk_i);
		cmp_rng("beat count", exp_q.size(), exp_q.size(), got_q.size());
		foreach (exp_q[i])
			if (i < got_q.size())
				cmp("beat", exp_q[i], got_q[i]);
		got_q.delete();
		exp_q.delete();
	endtask

	task automatic wait_pre(input logic [1:0] bank);
		for (int i = 0; i < 100 && pre_cnt == old; i++)
			@(posedge sys_clk_i);
		cmp_rng("precharge count", old + 1, old + 1, pre_cnt);
		cmp("precharge bank", {15'h0, bank}, {15'h0, pre_bank});
	endtask

	task automatic tally_and_finish();
		$display("checks %0d, errors %0d", checks_done, error_cnt);
		if (error_cnt == 0 && checks_done > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask

	initial begin
		#(40 * 30000);
		error_cnt++;
		tally_and_finish();
	end

	initial begin
		repeat (20) @(posedge sys_clk_i);
		rst_i <= 1'b0;
		for (int i = 0; i < 8; i++) begin
			cfg(bl_t[i], wcl_t[i], al_t[i], pl_t[i], 1'b0, 6'h0c);
			write(2'h0, 1'b0, i[0], 1'b0, n_t[i], 8'(i), 200);
			cmp("busy", 17'h00001, {16'h0000, busy_o});
			check_data();
			cmp_rng("write latency", lat_t[i], lat_t[i], first_cyc - rdy_cyc);
		end
		for (int i = 0; i < 5; i++) begin
			cfg(2'h0, 6'h09, 6'h00, 1'b0, dbi_t[i], 6'h0c);
			old = pre_cnt;
			// With inversion on, seeds with many ones make some beats travel inverted; the last seed wraps to zero.
			write(2'(i), wg_t[i], 1'b1, 1'b0, 8, 8'(8'hfc + i), 200);
			send(op_t[i], 2'(i), 1'b1, 1'b0, 1'b0, 300);
			cmp_rng("spacing", lo_t[i], lo_t[i] + 2, rdy_cyc - last_cyc);
			if (op_t[i] == ddrw_pkg::OP_PRE)
				wait_pre(2'(i));
			check_data();
		end
		cfg(2'h1, 6'h09, 6'h00, 1'b0, 1'b0, 6'h0a);
		old = pre_cnt;
		write(2'h3, 1'b0, 1'b0, 1'b1, 4, 8'h30, 200);
		wait_pre(2'h3);
		cmp_rng("auto precharge delay", 11, 12, pre_cyc - last_cyc);
		check_data();
		// The sink stalls so two full bursts fill the buffer and a third must wait.
		cfg(2'h0, 6'h09, 6'h00, 1'b0, 1'b0, 6'h0c);
		wdat_ready_i <= 1'b0;
		write(2'h0, 1'b0, 1'b0, 1'b0, 8, 8'h40, 200);
		write(2'h1, 1'b1, 1'b0, 1'b0, 8, 8'h41, 200);
		write(2'h2, 1'b0, 1'b0, 1'b0, 8, 8'h42, 60);
		cmp_rng("held write taken", 0, 0, int'(got));
		wdat_ready_i <= 1'b1;
		wait_rdy(200);
		cmp_rng("held write taken", 1, 1, int'(got));
		check_data();
		tally_and_finish();
	end
endmodule
